// ===== spp_map.vh
`ifndef SPP_MAP_VH
`define SPP_MAP_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SPP_CTRL_ADDR     8'hF8
`define SPP_DATA_ADDR     8'hA3
`define SPP_RATE_ADDR     8'hA2
`define SPP_CFG_ADDR      8'hA1
`define SPP_CTRL_RESET    8'h06
`define SPP_RATE_RESET    8'h00
`define SPP_CFG_RESET     8'h00
// ----------------------------------------
// Control fields
// ----------------------------------------
`define SPP_BIT_DONE      7
`define SPP_BIT_WRITE_COLLISION_FLAG      6
`define SPP_BIT_MODE_FAULT_FLAG      5
`define SPP_BIT_OVRN      4
`define SPP_SEL_HI        3
`define SPP_SEL_LO        2
`define SPP_BIT_TXE       1
`define SPP_BIT_EN        0
`define SPP_SEL_3WIRE     2'h0
`define SPP_SEL_INPUT     2'h1
`define SPP_SEL_LOW       2'h2
`define SPP_SEL_HIGH      2'h3
// ----------------------------------------
// Config fields
// ----------------------------------------
`define SPP_BIT_MASTER    0
`define SPP_BIT_PHASE     1
`define SPP_BIT_POL       2
// ----------------------------------------
// Timing
// ----------------------------------------
`define SPP_CLK_HZ        10000000
`define SPP_MAX_BIT_HZ    12500000
`define SPP_MIN_HALF_CYC  1
`endif

// ===== spp_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------
module spp_sync #(
  parameter W = 3
) (
  input  wire         ref_clk,
  input  wire         reset_n,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate
endmodule // spp_sync

// ===== spp_port.v
`timescale 1ns/1ps
`include "spp_map.vh"
// Operation
// RL1 - Set done flag at transfer end; stays set until software clears it.
// RL2 - Data write while buffer full is dropped and sets collision flag.
// RL3 - Master with select input mode and select low sets mode fault.
// RL4 - Slave only: last bit arriving with unread receive data sets overrun.
// RL5 - Select mode: 00 three-wire, 01 input, 10 drive low, 11 high.
// RL6 - Buffer-empty clears on data write, sets when byte enters shifter.
// RL7 - Software disables the port before changing clock phase or polarity.
// RL8 - Clock rate register sets master clock only; ignored as slave.
// RL9 - Master bit rate at most half system clock and 12.5 MHz.
// RL10 - Full-duplex external master stays at or below one tenth clock.
// RL11 - Receive-only external master may run at one quarter clock.
// RL12 - Master clock divided from system clock; each phase one cycle minimum.
module spp_port (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       sck_in,
  output reg        sck_out,
  output reg        sck_oe,
  input  wire       mosi_in,
  output reg        mosi_out,
  output reg        mosi_oe,
  input  wire       miso_in,
  output reg        miso_out,
  output reg        miso_oe,
  input  wire       slave_select_in,
  output reg        slave_select_out,
  output reg        slave_select_oe,
  output reg        irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LEAD = 3'b010;
  localparam [2:0] ST_TRAIL = 3'b100;
  localparam integer RATE_FLOOR_I = ((`SPP_CLK_HZ + `SPP_MAX_BIT_HZ - 1) / `SPP_MAX_BIT_HZ + 1) / 2 - 1;
  localparam [7:0]   RATE_FLOOR   = RATE_FLOOR_I[7:0];

  reg  [7:0] ctrl;
  reg  [7:0] rate;
  reg  [7:0] cfg;
  reg  [7:0] tx_buf;
  reg  [7:0] shifter;
  reg  [7:0] rx_buf;
  reg        rx_full;
  reg  [2:0] state;
  reg  [7:0] div_cnt;
  reg  [3:0] bit_cnt;
  reg        sample_bit;
  reg        sck_prev;
  reg        slv_active;
  wire [2:0] sync_q;

  wire       enabled = ctrl[`SPP_BIT_EN];
  wire       master  = cfg[`SPP_BIT_MASTER];
  wire       phase   = cfg[`SPP_BIT_PHASE];
  wire       pol     = cfg[`SPP_BIT_POL];
  wire [1:0] sel_mode = ctrl[`SPP_SEL_HI:`SPP_SEL_LO];
  wire       s_sck = sync_q[0];
  wire       s_mosi = sync_q[1];
  wire       s_sel = sync_q[2];

  spp_sync #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({slave_select_in, mosi_in, sck_in}),
    .sync_out (sync_q)
  );

  // ----------------------------------------
  // Derived events
  // ----------------------------------------
  wire [7:0] eff_rate = (rate < RATE_FLOOR) ? RATE_FLOOR : rate; // RL9
  wire       div_hit  = (div_cnt == eff_rate);                   // RL12
  wire       wr_ctrl  = reg_wr && (reg_addr == `SPP_CTRL_ADDR);
  wire       wr_data  = reg_wr && (reg_addr == `SPP_DATA_ADDR);
  wire       rd_data  = reg_rd && (reg_addr == `SPP_DATA_ADDR);
  wire       slv_sel  = (sel_mode == `SPP_SEL_3WIRE) ? 1'b1 : !s_sel;
  wire       slv_on   = enabled && !master && slv_sel;
  wire       sck_lvl  = s_sck ^ pol;
  wire       lead_e   = slv_on && sck_lvl && !sck_prev;
  wire       trail_e  = slv_on && !sck_lvl && sck_prev;
  wire       slv_smp  = phase ? trail_e : lead_e;
  wire       fault    = enabled && master && (sel_mode == `SPP_SEL_INPUT) && !s_sel; // RL3
  wire       m_start  = enabled && master && !fault && (state == ST_IDLE) && !ctrl[`SPP_BIT_TXE];
  wire       m_lead   = (state == ST_LEAD) && div_hit;
  wire       m_trail  = (state == ST_TRAIL) && div_hit;
  wire       m_smp    = phase ? m_trail : m_lead;
  wire       m_last   = m_trail && (bit_cnt == 4'h7);
  wire       s_load   = slv_on && !slv_active && !ctrl[`SPP_BIT_TXE];
  wire       s_last   = slv_smp && (bit_cnt == 4'h7);
  wire       xfer_end = m_last || s_last;
  wire       load     = m_start || s_load;
  wire [7:0] next_shift = {shifter[6:0], master ? miso_in : s_mosi};

  // ----------------------------------------
  // Control and status
  // ----------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl    <= `SPP_CTRL_RESET;
      rate    <= `SPP_RATE_RESET;
      cfg     <= `SPP_CFG_RESET;
      tx_buf  <= 8'h00;
      rx_buf  <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl[7:2] <= reg_wdata[7:2];
        ctrl[`SPP_BIT_EN] <= reg_wdata[`SPP_BIT_EN];
      end
      if (reg_wr && (reg_addr == `SPP_RATE_ADDR))
        rate <= reg_wdata;
      if (reg_wr && (reg_addr == `SPP_CFG_ADDR))
        cfg <= reg_wdata;
      if (wr_data && ctrl[`SPP_BIT_TXE]) begin
        tx_buf <= reg_wdata;
        ctrl[`SPP_BIT_TXE] <= 1'b0;                              // RL6
      end else if (load) begin
        ctrl[`SPP_BIT_TXE] <= 1'b1;                              // RL6
      end
      if (wr_data && !ctrl[`SPP_BIT_TXE])
        ctrl[`SPP_BIT_WRITE_COLLISION_FLAG] <= 1'b1;                             // RL2
      if (fault)
        ctrl[`SPP_BIT_MODE_FAULT_FLAG] <= 1'b1;                             // RL3
      if (s_last && rx_full)
        ctrl[`SPP_BIT_OVRN] <= 1'b1;                             // RL4
      if (xfer_end)
        ctrl[`SPP_BIT_DONE] <= 1'b1;                             // RL1
      if (xfer_end) begin
        rx_buf  <= next_shift;
        rx_full <= 1'b1;
      end else if (rd_data) begin
        rx_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= ST_IDLE;
      div_cnt    <= 8'h00;
      bit_cnt    <= 4'h0;
      shifter    <= 8'h00;
      sample_bit <= 1'b0;
      sck_prev   <= 1'b0;
      slv_active <= 1'b0;
    end else begin
      sck_prev <= sck_lvl;
      div_cnt  <= (state == ST_IDLE || div_hit) ? 8'h00 : div_cnt + 8'h01;
      if (load) begin
        shifter <= tx_buf;
        bit_cnt <= 4'h0;
      end
      case (state)
        ST_IDLE: begin
          if (m_start)
            state <= ST_LEAD;
        end
        ST_LEAD: begin
          if (!enabled || fault)
            state <= ST_IDLE;
          else if (div_hit)
            state <= ST_TRAIL;
        end
        ST_TRAIL: begin
          if (!enabled || fault || m_last)
            state <= ST_IDLE;
          else if (div_hit)
            state <= ST_LEAD;
        end
        default: state <= ST_IDLE;
      endcase
      if (m_smp)
        sample_bit <= miso_in;
      if (master && state != ST_IDLE && (phase ? m_lead : m_trail)) begin
        shifter <= {shifter[6:0], phase ? shifter[0] : sample_bit};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (s_load)
        slv_active <= 1'b1;
      else if (!slv_on || s_last)
        slv_active <= 1'b0;
      if (slv_smp) begin
        shifter <= next_shift;
        bit_cnt <= bit_cnt + 4'h1;
      end
      // Fresh bit count for every byte, with or without loaded data
      if (xfer_end || (state == ST_IDLE && !slv_on))
        bit_cnt <= 4'h0;
    end
  end

  // ----------------------------------------
  // Pins and read data
  // ----------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_out          <= 1'b0;
      sck_oe           <= 1'b0;
      mosi_out         <= 1'b0;
      mosi_oe          <= 1'b0;
      miso_out         <= 1'b0;
      miso_oe          <= 1'b0;
      slave_select_out <= 1'b0;
      slave_select_oe  <= 1'b0;
      irq              <= 1'b0;
      reg_rdata        <= 8'h00;
    end else begin
      sck_out  <= pol ^ (state == ST_TRAIL);                     // RL8
      sck_oe   <= enabled && master;
      mosi_out <= shifter[7];
      mosi_oe  <= enabled && master;
      miso_out <= shifter[7];
      miso_oe  <= slv_on;
      slave_select_out <= (sel_mode == `SPP_SEL_HIGH);           // RL5
      slave_select_oe  <= enabled && sel_mode[1];                // RL5
      irq <= |ctrl[7:4];                                         // RL1
      case (reg_addr)
        `SPP_CTRL_ADDR: reg_rdata <= ctrl;
        `SPP_DATA_ADDR: reg_rdata <= rx_buf;
        `SPP_RATE_ADDR: reg_rdata <= rate;
        `SPP_CFG_ADDR:  reg_rdata <= cfg;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule // spp_port

// ===== spp_port_properties.sv
`timescale 1ns/1ps
module spp_port_checker (
  input wire       ref_clk,
  input wire       reset_n,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       sck_out,
  input wire       sck_oe,
  input wire       slave_select_out,
  input wire       slave_select_oe,
  input wire       irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire      ctrl_wr = reg_wr && reg_addr == 8'hF8;
  wire      ctrl_en = ctrl_wr && reg_wdata[0];
  wire      sel_wr  = ctrl_en && reg_wdata[3];
  reg [7:0] rate_q;
  reg [8:0] hi_cnt;
  reg       master_q;
  // --------
  // Mirror of rate, role, high phase
  // --------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_q <= 8'h00;
      master_q <= 1'b0;
      hi_cnt <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == 8'hA2) begin
        rate_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == 8'hA1) begin
        master_q <= reg_wdata[0];
      end
      hi_cnt <= sck_out ? hi_cnt + 9'h001 : 9'h000;
    end
  end
  // --------
  // Properties
  // --------
  reset_out_a: assert property ($rose(reset_n) |-> !irq && !sck_oe)
    else $error("output active after reset");
  irq_mirror_a: assert property ($past(reg_addr) == 8'hF8 |-> (|reg_rdata[7:4]) == irq)
    else $error("irq differs from flags");
  flag_sticky_a: assert property (irq && !ctrl_wr && !$past(ctrl_wr) |=> irq)
    else $error("flag dropped unasked");
  sel_drive_a: assert property ($past(ctrl_en, 2) |-> slave_select_oe == $past(reg_wdata[3], 2))
    else $error("select enable wrong");
  sel_level_a: assert property ($past(sel_wr, 2) |-> slave_select_out == $past(reg_wdata[2], 2))
    else $error("select level wrong");
  half_period_a: assert property ($fell(sck_out) && sck_oe |-> hi_cnt == rate_q + 9'h001)
    else $error("clock high phase length wrong");
  slave_noclk_a: assert property (!master_q && !$past(master_q) |-> !sck_oe)
    else $error("slave drives clock");
  unmapped_zero_a: assert property ($past(reg_addr) == 8'h00 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property ($rose(irq));
  cover property ($fell(sck_out) && sck_oe);
  cover property (slave_select_oe && !slave_select_out);
endmodule // spp_port_checker
bind spp_port spp_port_checker i_spp_port_checker (.ref_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .sck_out, .sck_oe, .slave_select_out, .slave_select_oe, .irq);

// ===== spp_far_slave.sv
`timescale 1ns/1ps
module spp_far_slave (
  input  wire       sck,
  input  wire       mosi,
  input  wire       load,
  input  wire [7:0] reply,
  output wire       miso,
  output reg  [7:0] got
);
  reg [7:0] sh;
  assign miso = sh[7];
  always @(posedge sck) begin
    got <= {got[6:0], mosi};
  end
  // --------
  // Next bit on trailing edge; idle bits keep toggling
  // --------
  always @(negedge sck or posedge load) begin
    if (load) begin
      sh <= reply;
    end else begin
      sh <= {sh[6:0], ~sh[7]};
    end
  end
endmodule // spp_far_slave

// ===== test_serial_peripheral_port.sv
`timescale 1ns/1ps
module test_serial_peripheral_port;
  reg        ref_clk, reset_n, reg_wr, reg_rd, sck_tb, mosi_tb, ss_tb, load;
  reg  [7:0] reg_addr, reg_wdata, d;
  wire [7:0] reg_rdata, got;
  wire       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, slave_select_out, slave_select_oe, irq, far_miso;
  wire       sck_w = sck_oe ? sck_out : sck_tb;
  wire       mosi_w = mosi_oe ? mosi_out : mosi_tb;
  wire       miso_w = miso_oe ? miso_out : far_miso;
  wire       ss_w = slave_select_oe ? slave_select_out : ss_tb;
  integer    n_mismatch, checks_done, i, j;
  spp_port i_spp_port (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_in(ss_w), .slave_select_out(slave_select_out),
    .slave_select_oe(slave_select_oe), .irq(irq));
  spp_far_slave i_spp_far_slave (.sck(sck_w), .mosi(mosi_w), .load(load), .reply(8'h3C), .miso(far_miso),
    .got(got));
  always #50 ref_clk = ~ref_clk;
  task report_and_stop;
    begin
      if (n_mismatch == 0 && checks_done > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task cmp(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task chk(input [7:0] a, input [7:0] e);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      cmp(reg_rdata, e);
    end
  endtask
  task wait_done;
    begin
      d = 8'h00;
      @(posedge ref_clk);
      reg_addr <= 8'hF8;
      @(posedge ref_clk);
      for (j = 0; j < 400 && d[7] !== 1'b1; j = j + 1) begin
        @(negedge ref_clk);
        d = reg_rdata;
      end
      if (d[7] !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        report_and_stop;
      end
    end
  endtask
  // --------
  // External master, 800 ns clock, receive only
  // --------
  task slave_byte(input [7:0] v);
    begin
      @(posedge ref_clk);
      for (i = 7; i >= 0; i = i - 1) begin
        sck_tb <= 1'b0;
        mosi_tb <= v[i];
        repeat (4) @(posedge ref_clk);
        sck_tb <= 1'b1;
        repeat (4) @(posedge ref_clk);
      end
      sck_tb <= 1'b0;
      mosi_tb <= ~v[0];
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sck_tb = 1'b0;
    mosi_tb = 1'b0;
    ss_tb = 1'b1;
    load = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    load <= 1'b0;
    chk(8'hF8, 8'h06);
    chk(8'hA2, 8'h00);
    chk(8'hA1, 8'h00);
    chk(8'h00, 8'h00);
    for (j = 0; j < 4; j = j + 1) begin
      wr(8'hF8, {4'h0, j[1:0], 2'h1});
      repeat (2) @(negedge ref_clk);
      cmp({6'h00, slave_select_oe, slave_select_out}, {6'h00, j[1], j[1] & j[0]});
    end
    wr(8'hF8, 8'h00);
    wr(8'hA1, 8'h01);
    wr(8'hA2, 8'h01);
    wr(8'hF8, 8'h09);
    wr(8'hA3, 8'hA5);
    wr(8'hA3, 8'h5A);
    wr(8'hA3, 8'hC3);
    chk(8'hF8, 8'h49);
    wait_done;
    cmp(got, 8'hA5);
    chk(8'hA3, 8'h3C);
    wr(8'hF8, 8'h09);
    chk(8'hF8, 8'h0B);
    wait_done;
    cmp(got, 8'h5A);
    chk(8'hF8, 8'h8B);
    wr(8'hF8, 8'h04);
    repeat (4) @(posedge ref_clk);
    wr(8'hF8, 8'h05);
    chk(8'hF8, 8'h07);
    @(posedge ref_clk);
    ss_tb <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(8'hF8, 8'h27);
    ss_tb <= 1'b1;
    wr(8'hF8, 8'h00);
    wr(8'hA1, 8'h00);
    wr(8'hF8, 8'h01);
    wr(8'hA3, 8'hC5);
    repeat (3) @(negedge ref_clk);
    cmp({6'h00, miso_oe, miso_out}, 8'h03);
    chk(8'hF8, 8'h03);
    slave_byte(8'h96);
    slave_byte(8'h96);
    repeat (4) @(posedge ref_clk);
    chk(8'hF8, 8'h93);
    chk(8'hA3, 8'h96);
    report_and_stop;
  end
endmodule // test_serial_peripheral_port
